// File: wlm_pkg.sv
// wlm_pkg: constants, register map and command codes of the wlan module command controller
// assumes a 20 MHz ref_clk and a 32-bit axi4-lite register bus with 8-bit byte addresses
package wlm_pkg;
   localparam int CLK_NS   = 50;
   localparam int BOOT_NS  = 10000;
   localparam int BOOT_CYC = (BOOT_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_ARG    = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_RES    = 8'h0c;
   localparam logic [7:0] ADDR_RES_HI = 8'h10;
   localparam logic [7:0] ADDR_CONFIG = 8'h14;
   localparam logic [7:0] ADDR_PINS   = 8'h18;
   localparam logic [7:0] ADDR_TEXT   = 8'h20;
   localparam logic [7:0] ADDR_TEXT_E = 8'h3c;

   localparam logic [2:0] BAUD_115200 = 3'h4;
   localparam logic [2:0] BAUD_LAST   = 3'h6;
   localparam logic [1:0] PAR_NONE    = 2'h0;
   localparam logic [1:0] PAR_ODD     = 2'h2;
   localparam logic [3:0] DATA_BITS   = 4'h8;
   localparam logic [4:0] KEY_SHORT   = 5'h0a;
   localparam logic [4:0] KEY_LONG    = 5'h1a;
   localparam logic [1:0] REGION_LAST = 2'h2;
   localparam logic [3:0] CHAN_MAX0   = 4'hb;
   localparam logic [3:0] CHAN_MAX1   = 4'hd;
   localparam logic [3:0] CHAN_MAX2   = 4'he;
   localparam logic [3:0] CHAN_RST    = 4'h1;

   localparam logic [2:0] PM_0 = 3'h0;
   localparam logic [2:0] PM_1 = 3'h1;
   localparam logic [2:0] PM_2 = 3'h2;
   localparam logic [2:0] PM_5 = 3'h5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [7:0] {
      OP_SERIAL_SETUP  = 8'h01, OP_PRIVACY      = 8'h02, OP_KEY_LOAD     = 8'h03,
      OP_AUTH_MODE     = 8'h04, OP_SCAN         = 8'h05, OP_AP_JOIN      = 8'h06,
      OP_AP_LEAVE      = 8'h07, OP_NETWORK_TYPE = 8'h08, OP_CHANNEL      = 8'h09,
      OP_HW_IDENTITY   = 8'h0a, OP_POWER_SELECT = 8'h0b, OP_SIGNAL_QUERY = 8'h0c,
      OP_REGION_QUERY  = 8'h0d, OP_REGION_WRITE = 8'h0e, OP_ANALOG_SETUP = 8'h0f,
      OP_PIN_DIR_OUT   = 8'h10, OP_PIN_DIR_IN   = 8'h11, OP_PIN_HIGH     = 8'h12,
      OP_PIN_LOW       = 8'h13, OP_PIN_SAMPLE   = 8'h14, OP_FW_VERSION   = 8'h15
   } wlm_op_e;

   typedef enum logic [3:0] {
      ST_BOOT = 4'b0001,
      ST_IDLE = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_SCAN = 4'b1000
   } wlm_state_e;
endpackage

// File: wlm_cmd_ctrl.sv
// wlm_cmd_ctrl: command interpreter and power-mode controller behind an axi4-lite slave
// assumes radio-side strobes share ref_clk; dsr and gpio pins are asynchronous
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module wlm_cmd_ctrl
   import wlm_pkg::*;
#(
   parameter logic [47:0] MAC_ADDR   = 48'h02_00_00_00_00_01, // arbitrary value
   parameter logic [31:0] FW_VERSION = 32'h0000_0100          // arbitrary value
) (
   input  wire logic          ref_clk,
   input  wire logic          reset,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic               uart_rts_n,
   input  wire logic          uart_dsr_n,
   output logic [2:0]         baud_sel,
   output logic [1:0]         parity_sel,
   output logic               stop_two,
   output logic               radio_pwr_en,
   output logic               mcu_standby,
   input  wire logic          ap_pkt_rx,
   output logic               wep_en,
   output logic               auth_closed,
   output logic [127:0]       wep_key,
   output logic               key_long,
   output logic [127:0]       ssid,
   output logic               adhoc,
   output logic [3:0]         adhoc_channel,
   output logic               scan_start,
   input  wire logic          scan_done,
   input  wire logic [7:0]    scan_count,
   output logic               join_req,
   output logic               leave_req,
   input  wire logic [7:0]    rssi,
   output logic               adc_init,
   output logic               adc_chan,
   input  wire logic [11:0]   gpio_in,
   output logic [11:0]        gpio_out,
   output logic [11:0]        gpio_oe
);
   wlm_state_e   st_q;
   logic [15:0]  boot_cnt_q;
   logic         aw_have_q, w_have_q, bvalid_q, rvalid_q;
   logic [7:0]   aw_q;
   logic [31:0]  wd_q, rdata_q;
   logic [3:0]   ws_q;
   logic [1:0]   bresp_q, rresp_q;
   logic [7:0]   op_q;
   logic [31:0]  arg_q, res_q, res_hi_q;
   logic [31:0]  text_q [0:7];
   logic         err_q, done_q;
   logic [2:0]   mode_q, baud_q;
   logic [1:0]   par_q, region_q;
   logic         stop_q, wep_q, auth_q, long_q, adhoc_q, assoc_q, adc_chan_q;
   logic [3:0]   chan_q;
   logic         scan_q, join_q, leave_q, adc_q;
   logic [11:0]  dir_q, out_q, gpio_s1_q, gpio_s2_q;
   logic         dsr_s1_q, dsr_s2_q, wake_q, standby_q;

   // write path: address and data are taken independently, answered once both are in
   wire          wr_go   = aw_have_q && w_have_q && !bvalid_q;
   wire [31:0]   wmask   = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   wire          wr_text = (aw_q >= ADDR_TEXT) && (aw_q <= ADDR_TEXT_E) && (aw_q[1:0] == 2'h0);
   wire          wr_cmd  = (aw_q == ADDR_CMD);
   wire          wr_arg  = (aw_q == ADDR_ARG);
   wire          cmd_take = wr_go && wr_cmd && (st_q == ST_IDLE);
   wire          wr_ok   = (wr_cmd && (st_q == ST_IDLE)) || wr_arg || wr_text;
   wire [2:0]    text_ix = aw_q[4:2];

   wire          ar_go   = s_axi_arvalid && !rvalid_q;
   wire [7:0]    ra      = s_axi_araddr;
   wire          rd_text = (ra >= ADDR_TEXT) && (ra <= ADDR_TEXT_E) && (ra[1:0] == 2'h0);
   wire          rd_map  = (ra == ADDR_CMD) || (ra == ADDR_ARG) || (ra == ADDR_STATUS) ||
                           (ra == ADDR_RES) || (ra == ADDR_RES_HI) || (ra == ADDR_CONFIG) ||
                           (ra == ADDR_PINS) || rd_text;
   wire [31:0]   status_w = {16'h0, 5'h0, mode_q, 2'h0, standby_q, assoc_q,
                             !uart_rts_n, err_q, done_q, (st_q != ST_IDLE)};
   wire [31:0]   config_w = {12'h0, region_q, chan_q, adhoc_q, long_q, auth_q, wep_q,
                             stop_q, par_q, baud_q, DATA_BITS};
   wire [31:0]   rd_w = (ra == ADDR_CMD)    ? {24'h0, op_q} :
                        (ra == ADDR_ARG)    ? arg_q :
                        (ra == ADDR_STATUS) ? status_w :
                        (ra == ADDR_RES)    ? res_q :
                        (ra == ADDR_RES_HI) ? res_hi_q :
                        (ra == ADDR_CONFIG) ? config_w :
                        (ra == ADDR_PINS)   ? {4'h0, out_q, 4'h0, dir_q} :
                        rd_text             ? text_q[ra[4:2]] : 32'h0;

   // command checking
   wire [3:0]    chan_max = (region_q == 2'h0) ? CHAN_MAX0 :
                            (region_q == 2'h1) ? CHAN_MAX1 : CHAN_MAX2;
   wire [3:0]    rmax_new = (arg_q[1:0] == 2'h0) ? CHAN_MAX0 :
                            (arg_q[1:0] == 2'h1) ? CHAN_MAX1 : CHAN_MAX2;
   wire [11:0]   pmask    = arg_q[11:0];
   wire          m5_allow = (op_q == OP_SERIAL_SETUP) || (op_q == OP_POWER_SELECT) ||
                            (op_q == OP_HW_IDENTITY) || (op_q == OP_FW_VERSION);
   wire          pm_valid = (arg_q[2:0] == PM_0) || (arg_q[2:0] == PM_1) ||
                            (arg_q[2:0] == PM_2) || (arg_q[2:0] == PM_5);
   logic         arg_ok;
   always_comb begin
      case (op_q)
         OP_SERIAL_SETUP: arg_ok = (arg_q[2:0] <= BAUD_LAST) && (arg_q[7:4] == DATA_BITS) &&
                                   (arg_q[9:8] <= PAR_ODD);
         OP_KEY_LOAD:     arg_ok = (arg_q[4:0] == KEY_SHORT) || (arg_q[4:0] == KEY_LONG);
         OP_NETWORK_TYPE: arg_ok = !(arg_q[0] && (mode_q == PM_1));
         OP_CHANNEL:      arg_ok = (arg_q[3:0] != 4'h0) && (arg_q[3:0] <= chan_max);
         OP_POWER_SELECT: arg_ok = pm_valid && !(adhoc_q && (arg_q[2:0] == PM_1));
         OP_SIGNAL_QUERY: arg_ok = assoc_q;
         OP_REGION_WRITE: arg_ok = (arg_q[1:0] <= REGION_LAST) && (chan_q <= rmax_new);
         OP_ANALOG_SETUP: arg_ok = (arg_q[31:1] == 31'h0);
         OP_PRIVACY, OP_AUTH_MODE, OP_SCAN, OP_AP_JOIN, OP_AP_LEAVE, OP_HW_IDENTITY,
         OP_REGION_QUERY, OP_PIN_DIR_OUT, OP_PIN_DIR_IN, OP_PIN_HIGH, OP_PIN_LOW,
         OP_PIN_SAMPLE, OP_FW_VERSION: arg_ok = 1'b1;
         default:         arg_ok = 1'b0;
      endcase
   end
   // a command is refused while in mode 5 unless whitelisted, or while standing by
   wire          cmd_ok = arg_ok && ((mode_q != PM_5) || m5_allow) && !standby_q;
   wire          exec_ok = (st_q == ST_EXEC) && cmd_ok;
   wire          is_op_arg = exec_ok && (op_q == OP_SERIAL_SETUP);

   // gpio and dsr pins from outside pass two flops before use
   always_ff @(posedge ref_clk) begin
      gpio_s1_q <= gpio_in;
      gpio_s2_q <= gpio_s1_q;
      dsr_s1_q  <= uart_dsr_n;
      dsr_s2_q  <= dsr_s1_q;
   end

   // bus slave
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         aw_q      <= 8'h0;
         wd_q      <= 32'h0;
         ws_q      <= 4'h0;
         bresp_q   <= RESP_OKAY;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= 32'h0;
      end else begin
         if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_q      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            wd_q     <= s_axi_wdata;
            ws_q     <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (ar_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_w;
            rresp_q  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // key and network-name words, honouring byte strobes
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_text
         always_ff @(posedge ref_clk) begin
            if (reset) begin
               text_q[gi] <= 32'h0;
            end else if (wr_go && wr_text && (text_ix == gi)) begin
               text_q[gi] <= (text_q[gi] & ~wmask) | (wd_q & wmask);
            end
         end
      end
   endgenerate

   // sequencer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_q       <= ST_BOOT;
         boot_cnt_q <= 16'h0;
         op_q       <= 8'h0;
         arg_q      <= 32'h0;
         err_q      <= 1'b0;
         done_q     <= 1'b0;
         res_q      <= 32'h0;
         res_hi_q   <= 32'h0;
      end else begin
         if (wr_go && wr_arg) begin
            arg_q <= (arg_q & ~wmask) | (wd_q & wmask);
         end
         case (st_q)
            ST_BOOT: begin
               boot_cnt_q <= boot_cnt_q + 16'h1;
               if (boot_cnt_q == 16'(BOOT_CYC - 1)) begin
                  st_q <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (cmd_take) begin
                  op_q   <= wd_q[7:0];
                  done_q <= 1'b0;
                  st_q   <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               err_q <= !cmd_ok;
               if (exec_ok && (op_q == OP_SCAN)) begin
                  st_q <= ST_SCAN;
               end else begin
                  done_q <= 1'b1;
                  st_q   <= ST_IDLE;
               end
               if (exec_ok) begin
                  case (op_q)
                     OP_HW_IDENTITY: begin
                        res_q    <= MAC_ADDR[31:0];
                        res_hi_q <= {16'h0, MAC_ADDR[47:32]};
                     end
                     OP_SIGNAL_QUERY: res_q <= {24'h0, rssi};
                     OP_REGION_QUERY: res_q <= {30'h0, region_q};
                     OP_PIN_SAMPLE:   res_q <= {20'h0, gpio_s2_q & ~dir_q & pmask};
                     OP_FW_VERSION:   res_q <= FW_VERSION;
                     default:         res_q <= res_q;
                  endcase
               end
            end
            ST_SCAN: begin
               if (scan_done) begin
                  res_q  <= {24'h0, scan_count};
                  done_q <= 1'b1;
                  st_q   <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // configuration and mode state
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mode_q   <= PM_5;
         baud_q   <= BAUD_115200;
         par_q    <= PAR_NONE;
         stop_q   <= 1'b0;
         wep_q    <= 1'b0;
         auth_q   <= 1'b0;
         long_q   <= 1'b0;
         adhoc_q  <= 1'b0;
         assoc_q  <= 1'b0;
         chan_q   <= CHAN_RST;
         region_q <= 2'h0;
         dir_q    <= 12'h0;
         out_q    <= 12'h0;
         adc_chan_q <= 1'b0;
      end else if (exec_ok) begin
         case (op_q)
            OP_SERIAL_SETUP: begin
               baud_q <= arg_q[2:0];
               par_q  <= arg_q[9:8];
               stop_q <= arg_q[12];
            end
            OP_PRIVACY:      wep_q    <= arg_q[0];
            OP_KEY_LOAD:     long_q   <= (arg_q[4:0] == KEY_LONG);
            OP_AUTH_MODE:    auth_q   <= arg_q[0];
            OP_AP_JOIN:      assoc_q  <= 1'b1;
            OP_AP_LEAVE:     assoc_q  <= 1'b0;
            OP_NETWORK_TYPE: adhoc_q  <= arg_q[0];
            OP_CHANNEL:      chan_q   <= arg_q[3:0];
            OP_POWER_SELECT: mode_q   <= arg_q[2:0];
            OP_REGION_WRITE: region_q <= arg_q[1:0];
            OP_ANALOG_SETUP: adc_chan_q <= arg_q[0];
            OP_PIN_DIR_OUT:  dir_q    <= dir_q | pmask;
            OP_PIN_DIR_IN:   dir_q    <= dir_q & ~pmask;
            OP_PIN_HIGH:     out_q    <= out_q | (pmask & dir_q);
            OP_PIN_LOW:      out_q    <= out_q & ~(pmask & dir_q);
            default:         mode_q   <= mode_q;
         endcase
      end
   end

   // one-cycle strobes to radio and converter; mode 2 standby tracking
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scan_q    <= 1'b0;
         join_q    <= 1'b0;
         leave_q   <= 1'b0;
         adc_q     <= 1'b0;
         wake_q    <= 1'b0;
         standby_q <= 1'b0;
      end else begin
         scan_q  <= exec_ok && (op_q == OP_SCAN);
         join_q  <= exec_ok && (op_q == OP_AP_JOIN);
         leave_q <= exec_ok && (op_q == OP_AP_LEAVE);
         adc_q   <= exec_ok && (op_q == OP_ANALOG_SETUP);
         // a packet wakes until dsr is next asserted, so the host regains control first
         if (!dsr_s2_q) begin
            wake_q <= 1'b0;
         end else if (ap_pkt_rx) begin
            wake_q <= 1'b1;
         end
         standby_q <= (mode_q == PM_2) && dsr_s2_q && !ap_pkt_rx && !wake_q &&
                      (st_q == ST_IDLE);
      end
   end

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready  = !w_have_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign uart_rts_n    = (st_q == ST_BOOT);
   assign baud_sel      = baud_q;
   assign parity_sel    = par_q;
   assign stop_two      = stop_q;
   assign radio_pwr_en  = (mode_q != PM_5);
   assign mcu_standby   = standby_q;
   assign wep_en        = wep_q;
   assign auth_closed   = auth_q;
   assign key_long      = long_q;
   assign wep_key       = {text_q[3], text_q[2], text_q[1], text_q[0]};
   assign ssid          = {text_q[7], text_q[6], text_q[5], text_q[4]};
   assign adhoc         = adhoc_q;
   assign adhoc_channel = chan_q;
   assign scan_start    = scan_q;
   assign join_req      = join_q;
   assign leave_req     = leave_q;
   assign adc_init      = adc_q;
   assign adc_chan      = adc_chan_q;
   assign gpio_out      = out_q;
   assign gpio_oe       = dir_q;

   a_rts_boot: assert property (@(posedge ref_clk) disable iff (reset)
      (boot_cnt_q < 16'(BOOT_CYC - 1)) |-> uart_rts_n) else $error("rts asserted early");
   a_start_mode: assert property (@(posedge ref_clk)
      $fell(reset) |-> (mode_q == PM_5) && !radio_pwr_en && (baud_sel == BAUD_115200))
      else $error("bad start-up state");
   a_mode5_gate: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q == ST_EXEC) && (mode_q == PM_5) && !m5_allow |=> err_q && $stable(mode_q))
      else $error("command run in mode 5");
   a_pm_values: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q == ST_EXEC) && (op_q == OP_POWER_SELECT) && !pm_valid |=> err_q && $stable(mode_q))
      else $error("bad power mode taken");
   a_adhoc_no_m1: assert property (@(posedge ref_clk) disable iff (reset)
      !(adhoc_q && (mode_q == PM_1))) else $error("mode 1 while ad-hoc");
   a_chan_range: assert property (@(posedge ref_clk) disable iff (reset)
      (chan_q != 4'h0) && (chan_q <= chan_max)) else $error("channel out of region");
   a_key_len: assert property (@(posedge ref_clk) disable iff (reset)
      (st_q == ST_EXEC) && (op_q == OP_KEY_LOAD) && (arg_q[4:0] != KEY_SHORT) &&
      (arg_q[4:0] != KEY_LONG) |=> err_q && done_q) else $error("bad key length taken");
   a_drive_high: assert property (@(posedge ref_clk) disable iff (reset)
      exec_ok && (op_q == OP_PIN_HIGH) |=> ((gpio_out & $past(pmask & dir_q)) ==
      $past(pmask & dir_q))) else $error("pins not driven high");
   a_standby_m2: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(mcu_standby) |-> (mode_q == PM_2) && $past(dsr_s2_q))
      else $error("standby outside mode 2");
   a_serial_8n: assert property (@(posedge ref_clk) disable iff (reset)
      is_op_arg |=> (baud_sel == $past(arg_q[2:0])) && (parity_sel != 2'h3))
      else $error("serial setup not applied");
endmodule

// File: wlm_radio_model.sv
// wlm_radio_model: radio-side stand-in answering scans and reporting signal strength
// assumes it shares ref_clk with the controller and sees scan_start as a one-cycle pulse
`timescale 1ns/1ps
module wlm_radio_model (
   input  wire logic       ref_clk,
   input  wire logic       scan_start,
   input  wire logic       pkt_kick,
   output logic            scan_done,
   output logic [7:0]      scan_count,
   output logic [7:0]      rssi,
   output logic            ap_pkt_rx
);
   logic [3:0] wait_q = 4'h0;
   logic       pkt_q  = 1'b0;
   // count only holds beside done; otherwise its inverse, so a stale sample shows up
   assign scan_count = scan_done ? 8'h03 : 8'hfc;
   assign scan_done  = (wait_q == 4'h1);
   assign rssi       = 8'h2a;
   // a packet from the access point is as long as the kick pulse, launched a clock after the kick
   assign ap_pkt_rx  = pkt_q;
   always @(posedge ref_clk) begin
      pkt_q <= pkt_kick;
      if (scan_start) begin
         wait_q <= 4'h6;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end
   end
endmodule

// File: test_wlan_module_command_power_ctrl.sv
// test_wlan_module_command_power_ctrl: self-checking bench for the command controller
// assumes the radio model on the far side and an axi4-lite master in this bench
`timescale 1ns/1ps
module test_wlan_module_command_power_ctrl;
   import wlm_pkg::*;
   // bready and rready stay high: the bench always accepts an answer at once
   logic         ref_clk = 1'b0, reset = 1'b1, uart_dsr_n = 1'b0, s_axi_bready = 1'b1;
   logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic         s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic         s_axi_arready, s_axi_rvalid, uart_rts_n, stop_two, radio_pwr_en;
   logic         mcu_standby, ap_pkt_rx, wep_en, auth_closed, key_long, adhoc, scan_start;
   logic         scan_done, join_req, leave_req, adc_init, adc_chan;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, scan_count, rssi;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0]   s_axi_wstrb = 4'hf, adhoc_channel;
   logic [1:0]   s_axi_bresp, s_axi_rresp, parity_sel, r;
   logic [2:0]   baud_sel;
   logic [127:0] wep_key, ssid;
   logic [11:0]  gpio_in = 12'h5a5, gpio_out, gpio_oe;
   int           num_errors = 0, tests_run = 0;
   logic         pkt_kick = 1'b0;
   // one nibble per strobe: join, leave, converter, scan; each pulse counts once
   logic [15:0]  pulse_cnt = 16'h0;
   // mac value is arbitrary
   wlm_cmd_ctrl #(.MAC_ADDR(48'h02_00_00_00_12_34)) DUT (.ref_clk, .reset, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart_rts_n, .uart_dsr_n,
      .baud_sel, .parity_sel, .stop_two, .radio_pwr_en, .mcu_standby, .ap_pkt_rx, .wep_en,
      .auth_closed, .wep_key, .key_long, .ssid, .adhoc, .adhoc_channel, .scan_start, .scan_done,
      .scan_count, .join_req, .leave_req, .rssi, .adc_init, .adc_chan, .gpio_in, .gpio_out,
      .gpio_oe);
   wlm_radio_model radio (.ref_clk, .scan_start, .pkt_kick, .scan_done, .scan_count, .rssi,
      .ap_pkt_rx);
   always @(posedge ref_clk) pulse_cnt <= pulse_cnt + {3'h0, join_req, 3'h0, leave_req,
      3'h0, adc_init, 3'h0, scan_start};
   always #25 ref_clk = ~ref_clk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // address and data go out together; each is dropped the edge it is taken
   task wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask
   task rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
   endtask
   // done clears when a command is taken, so polling for done alone cannot see the last one
   task cmd(input logic [7:0] op, input logic [31:0] arg, input logic err);
      wr(ADDR_ARG, arg);
      wr(ADDR_CMD, {24'h0, op});
      d = 32'h0;
      for (int i = 0; i < 40 && !(d[1] && !d[0]); i++) rd(ADDR_STATUS);
      chk(d[1:0], 2'b10);
      chk(d[2], err);
   endtask
   task t_boot;
      chk({uart_rts_n, radio_pwr_en}, 2'b10);
      chk({baud_sel, parity_sel, stop_two}, {BAUD_115200, PAR_NONE, 1'b0});
      wr(ADDR_CMD, 32'h15);
      chk(r, RESP_SLVERR);
      for (int i = 0; i < 300 && uart_rts_n; i++) @(posedge ref_clk);
      chk(uart_rts_n, 1'b0);
   endtask
   task t_mode5;
      cmd(OP_SCAN, 0, 1'b1);
      cmd(OP_FW_VERSION, 0, 1'b0);
      cmd(OP_HW_IDENTITY, 0, 1'b0);
      rd(ADDR_RES);
      chk(d, 32'h0000_1234);
      rd(ADDR_RES_HI);
      chk(d, 32'h0000_0200);
      cmd(OP_SERIAL_SETUP, 32'h1286, 1'b0);
      chk({baud_sel, parity_sel, stop_two}, {3'h6, 2'h2, 1'b1});
      cmd(OP_SERIAL_SETUP, 32'h1276, 1'b1);
      cmd(OP_SERIAL_SETUP, 32'h0087, 1'b1);
      chk({baud_sel, parity_sel, stop_two}, {3'h6, 2'h2, 1'b1});
      cmd(OP_POWER_SELECT, 32'h3, 1'b1);
      cmd(OP_POWER_SELECT, 32'h0, 1'b0);
      chk(radio_pwr_en, 1'b1);
   endtask
   task t_config;
      cmd(OP_SCAN, 0, 1'b0);
      rd(ADDR_RES);
      chk(d, 32'h3);
      cmd(OP_KEY_LOAD, 32'd11, 1'b1);
      cmd(OP_KEY_LOAD, 32'd26, 1'b0);
      chk(key_long, 1'b1);
      cmd(OP_NETWORK_TYPE, 32'h1, 1'b0);
      chk(adhoc, 1'b1);
      cmd(OP_POWER_SELECT, 32'h1, 1'b1);
      cmd(OP_CHANNEL, 32'd12, 1'b1);
      cmd(OP_CHANNEL, 32'd11, 1'b0);
      chk(adhoc_channel, 4'hb);
      cmd(OP_PIN_DIR_OUT, 32'h0f0, 1'b0);
      cmd(OP_PIN_HIGH, 32'h0ff, 1'b0);
      chk({gpio_oe, gpio_out}, {12'h0f0, 12'h0f0});
   endtask
   task t_link;
      cmd(OP_PRIVACY, 32'h1, 1'b0);
      chk(wep_en, 1'b1);
      cmd(OP_AUTH_MODE, 32'h1, 1'b0);
      chk(auth_closed, 1'b1);
      wr(ADDR_TEXT, 32'h89ab_cdef);
      chk(wep_key[31:0], 32'h89ab_cdef);
      wr(ADDR_TEXT + 8'h10, 32'h6e65_7477);
      chk(ssid[31:0], 32'h6e65_7477);
      cmd(OP_SIGNAL_QUERY, 0, 1'b1);
      cmd(OP_AP_JOIN, 0, 1'b0);
      chk(d[4], 1'b1);
      cmd(OP_SIGNAL_QUERY, 0, 1'b0);
      rd(ADDR_RES);
      chk(d, 32'h2a);
      cmd(OP_AP_LEAVE, 0, 1'b0);
      chk(d[4], 1'b0);
      cmd(OP_REGION_WRITE, 32'h3, 1'b1);
      cmd(OP_REGION_WRITE, 32'h2, 1'b0);
      cmd(OP_REGION_QUERY, 0, 1'b0);
      rd(ADDR_RES);
      chk(d, 32'h2);
      cmd(OP_ANALOG_SETUP, 32'h2, 1'b1);
      cmd(OP_ANALOG_SETUP, 32'h1, 1'b0);
      chk(adc_chan, 1'b1);
      cmd(OP_PIN_DIR_IN, 32'h030, 1'b0);
      cmd(OP_PIN_LOW, 32'h0c0, 1'b0);
      chk({gpio_oe, gpio_out}, {12'h0c0, 12'h030});
      cmd(OP_PIN_SAMPLE, 32'hfff, 1'b0);
      rd(ADDR_RES);
      chk(d, 32'h525);
   endtask
   task t_standby;
      cmd(OP_NETWORK_TYPE, 32'h0, 1'b0);
      cmd(OP_POWER_SELECT, 32'h2, 1'b0);
      uart_dsr_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(mcu_standby, 1'b1);
      cmd(OP_FW_VERSION, 0, 1'b1);
      uart_dsr_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(mcu_standby, 1'b0);
      uart_dsr_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk(mcu_standby, 1'b1);
      pkt_kick <= 1'b1;
      @(posedge ref_clk);
      pkt_kick <= 1'b0;
      repeat (8) @(posedge ref_clk);
      chk(mcu_standby, 1'b0);
      uart_dsr_n <= 1'b0;
   endtask
   task results;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      t_boot;
      t_mode5;
      t_config;
      t_link;
      t_standby;
      chk(pulse_cnt, 16'h1111);
      results;
   end
   // roughly 35 commands of eight or so cycles each; far below this span
   initial begin
      #1000000;
      num_errors++;
      results;
   end
endmodule
